/* File: hdl/cta_pkg.sv */
// Package for the coexistence traffic arbiter port.
// Assumes a single 25 MHz core clock and synchronous pin inputs.
package cta_pkg;

  // Priority sampling scheme
  typedef enum logic [0:0] {
    CTA_PRI_ONE = 1'h0,
    CTA_PRI_TWO = 1'h1
  } cta_pri_mode_t;

  // Request handling states
  typedef enum logic [2:0] {
    CTA_IDLE  = 3'h0,
    CTA_PRI0  = 3'h1,
    CTA_PRI1  = 3'h2,
    CTA_DIR   = 3'h3,
    CTA_DECIDE = 3'h4,
    CTA_HOLD  = 3'h5
  } cta_state_t;

  // Direction encoding on the direction line
  localparam logic DIR_TX      = 1'h1;
  localparam logic DIR_RX      = 1'h0;
  localparam logic DIR_DEFAULT = DIR_TX;

  // Priority value loaded at reset and when a new request is seen
  localparam logic [1:0] PRI_RESET = 2'h0;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_LINES  = 4;

endpackage : cta_pkg

/* File: hdl/cta_sync_if.sv */
// Interface carrying the synchronised coexistence lines.
// Assumes the producer runs on the core clock.
`timescale 1ns/10ps
interface cta_sync_if;
  logic request;
  logic priority_bit;
  logic direction;
  logic band_overlap;
  modport src (output request, output priority_bit, output direction, output band_overlap);
  modport dst (input request, input priority_bit, input direction, input band_overlap);
endinterface : cta_sync_if

/* File: hdl/cta_sync.sv */
// Two-stage synchroniser for the four coexistence inputs.
// Assumes resetn_sync is already released synchronously.
`timescale 1ns/10ps
module cta_sync (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn_sync,
  // Raw pins
  input  wire logic [3:0]        raw_in,
  // Synchronised lines
  cta_sync_if.src                sync_out
);

  logic [3:0] stage1;
  logic [3:0] stage2;

  // Per-line double flop; stage1 feeds stage2 only
  genvar i;
  generate
    for (i = 0; i < cta_pkg::SYNC_LINES; i++) begin : g_line
      always_ff @(posedge core_clk or negedge resetn_sync) begin
        if (!resetn_sync) begin
          stage1[i] <= 1'h0;
          stage2[i] <= 1'h0;
        end else begin
          stage1[i] <= raw_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  // Line mapping
  assign sync_out.request      = stage2[0];
  assign sync_out.priority_bit = stage2[1];
  assign sync_out.direction    = stage2[2];
  assign sync_out.band_overlap = stage2[3];

endmodule : cta_sync

/* File: hdl/cta_arbiter.sv */
// Device-side packet traffic arbiter port: peer request in, grant out.
// Assumes pins are synchronous-rate levels and configuration straps are static.
//
// Behaviour
// - Device always drives grant output
// - Direction high transmit, low receive, default transmit
// - Band overlap high means overlap, used
// - Priority sampled once or twice per request
// - Without direction line, direction follows priority; without priority line too, it defaults to transmit
// - Works with only request and grant
`timescale 1ns/10ps
module cta_arbiter (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Peer radio lines
  input  wire logic       peer_request,
  input  wire logic       peer_priority,
  input  wire logic       peer_direction,
  input  wire logic       peer_band_overlap,
  output logic            peer_grant,
  // Configuration
  input  wire logic       cfg_pri_used,
  input  wire logic       cfg_pri_two,
  input  wire logic       cfg_dir_used,
  input  wire logic       cfg_band_used,
  input  wire logic [1:0] cfg_pri_threshold,
  // Local radio activity
  input  wire logic       local_busy,
  input  wire logic       local_tx,
  // Status
  output logic [1:0]      req_priority,
  output logic            req_direction
);

  // Reset release through two flops
  logic rst_ff1;
  logic resetn_sync;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_ff1     <= 1'h0;
      resetn_sync <= 1'h0;
    end else begin
      rst_ff1     <= 1'h1;
      resetn_sync <= rst_ff1;
    end
  end

  // Input synchroniser
  cta_sync_if sync_bus ();
  cta_sync u_sync (
    .core_clk    (core_clk),
    .resetn_sync (resetn_sync),
    .raw_in      ({peer_band_overlap, peer_direction, peer_priority, peer_request}),
    .sync_out    (sync_bus.src)
  );

  cta_pkg::cta_state_t state;
  cta_pkg::cta_state_t next_state;
  logic [1:0] pri;
  logic [1:0] next_pri;
  logic       dir;
  logic       next_dir;
  logic       grant;
  logic       next_grant;
  logic       win;
  logic       overlap;

  // Decision: grant when no conflict or peer priority high enough
  always_comb begin
    overlap = cfg_band_used ? sync_bus.band_overlap : 1'h1;
    win     = !local_busy || !overlap || (cfg_pri_used && pri >= cfg_pri_threshold);
    if (local_busy && overlap && dir == cta_pkg::DIR_RX && !local_tx) begin
      win = win || !cfg_pri_used; // Receive beside receive is tolerated only when priority is not used
    end
  end

  // Sampling sequence and grant state
  always_comb begin
    next_state = state;
    next_pri   = pri;
    next_dir   = dir;
    next_grant = grant;
    case (state)
      cta_pkg::CTA_IDLE: begin
        next_grant = 1'h0;
        if (sync_bus.request) begin
          next_pri = cta_pkg::PRI_RESET;
          next_dir = cfg_dir_used ? sync_bus.direction : cta_pkg::DIR_DEFAULT;
          next_state = cfg_pri_used ? cta_pkg::CTA_PRI0 : cta_pkg::CTA_DECIDE;
        end
      end
      cta_pkg::CTA_PRI0: begin
        next_pri = {1'h0, sync_bus.priority_bit};
        if (cfg_pri_two) begin
          next_state = cta_pkg::CTA_PRI1;
        end else if (!cfg_dir_used) begin
          next_state = cta_pkg::CTA_DIR;
        end else begin
          next_state = cta_pkg::CTA_DECIDE;
        end
      end
      cta_pkg::CTA_PRI1: begin
        next_pri   = {pri[0], sync_bus.priority_bit};
        next_state = cfg_dir_used ? cta_pkg::CTA_DECIDE : cta_pkg::CTA_DIR;
      end
      cta_pkg::CTA_DIR: begin
        next_dir   = sync_bus.priority_bit;
        next_state = cta_pkg::CTA_DECIDE;
      end
      cta_pkg::CTA_DECIDE: begin
        next_grant = win;
        next_state = cta_pkg::CTA_HOLD;
        if (!sync_bus.request) begin
          next_grant = 1'h0;
          next_state = cta_pkg::CTA_IDLE;
        end
      end
      cta_pkg::CTA_HOLD: begin
        if (!sync_bus.request) begin
          next_grant = 1'h0;
          next_state = cta_pkg::CTA_IDLE;
        end else begin
          next_grant = win;
        end
      end
      default: begin
        next_state = cta_pkg::CTA_IDLE;
        next_grant = 1'h0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge resetn_sync) begin
    if (!resetn_sync) begin
      state <= cta_pkg::CTA_IDLE;
      pri   <= cta_pkg::PRI_RESET;
      dir   <= cta_pkg::DIR_DEFAULT;
      grant <= 1'h0;
    end else begin
      state <= next_state;
      pri   <= next_pri;
      dir   <= next_dir;
      grant <= next_grant;
    end
  end

  // Outputs straight from flops
  assign peer_grant    = grant;
  assign req_priority  = pri;
  assign req_direction = dir;

  // Grant only while a request stands
  grant_needs_req_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    peer_grant |-> $past(sync_bus.request))
    else $error("grant without request");

  // Grant drops within two cycles of request release
  grant_drop_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    $fell(sync_bus.request) |-> ##[1:2] !peer_grant)
    else $error("grant not released");

  // Bare request/grant: idle local side grants two cycles after the request is seen
  sequence bare_req_s;
    !cfg_pri_used && !local_busy && state == cta_pkg::CTA_IDLE && sync_bus.request;
  endsequence
  bare_grant_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    bare_req_s ##1 sync_bus.request[*2] |-> peer_grant)
    else $error("bare grant missing");

  // Direction defaults to transmit without direction line or priority
  dir_default_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    (state == cta_pkg::CTA_IDLE && sync_bus.request && !cfg_dir_used && !cfg_pri_used)
    |=> req_direction == cta_pkg::DIR_TX)
    else $error("direction default wrong");

  // Direction line latched with the request when it is wired
  dir_line_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    (state == cta_pkg::CTA_IDLE && sync_bus.request && cfg_dir_used)
    |=> req_direction == $past(sync_bus.direction))
    else $error("direction line not taken");

  // Two-bit priority assembled from two samples
  sequence two_pri_s;
    state == cta_pkg::CTA_PRI0 && cfg_pri_two ##1 state == cta_pkg::CTA_PRI1;
  endsequence
  pri_two_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    two_pri_s |=> req_priority == {$past(sync_bus.priority_bit, 2),
                                   $past(sync_bus.priority_bit)})
    else $error("two bit priority wrong");

  // Direction taken from priority line after priority bits
  dir_on_pri_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    state == cta_pkg::CTA_DIR |=> req_direction == $past(sync_bus.priority_bit))
    else $error("direction from priority wrong");

  // No overlap means grant despite local traffic
  no_overlap_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    (state == cta_pkg::CTA_HOLD && sync_bus.request && cfg_band_used
     && !sync_bus.band_overlap) |=> peer_grant)
    else $error("non-overlap not granted");

  // Idle local radio always lets a held request through
  hold_idle_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    (state == cta_pkg::CTA_HOLD && sync_bus.request && !local_busy) |=> peer_grant)
    else $error("grant missing while local idle");

  // Busy transmitting local radio refuses a bare overlapping request
  refuse_busy_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    (state == cta_pkg::CTA_HOLD && sync_bus.request && local_busy && local_tx
     && overlap && !cfg_pri_used) |=> !peer_grant)
    else $error("grant despite busy local radio");

  // Synchroniser adds two cycles of latency on the rising request
  sync_delay_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    $rose(peer_request) |-> ##2 $rose(sync_bus.request))
    else $error("sync latency wrong");

  // Request release crosses the synchroniser in the same two cycles
  sync_fall_a: assert property (@(posedge core_clk) disable iff (!resetn_sync)
    $fell(peer_request) |-> ##2 $fell(sync_bus.request))
    else $error("sync release latency wrong");

endmodule : cta_arbiter

/* File: dv/cta_peer_model.sv */
// Peer radio model: request, serial priority, direction, overlap.
// Assumes the bench holds start for a whole request and changes it at falling edges.
`timescale 1ns/10ps
module cta_peer_model (
  // Clock
  input  wire logic       core_clk,
  // Bench control
  input  wire logic       start,
  input  wire logic [1:0] pri_val,
  input  wire logic       two_bit,
  input  wire logic       dir_on_pri,
  input  wire logic       dir,
  input  wire logic       overlap,
  // Lines toward the device
  output logic            peer_request,
  output logic            peer_priority,
  output logic            peer_direction,
  output logic            peer_band_overlap
);
  logic [2:0] seq;
  logic [2:0] load;

  initial begin
    peer_request = 1'h0;
    peer_priority = 1'h0;
    peer_direction = 1'h0;
    peer_band_overlap = 1'h0;
    seq = 3'h0;
  end

  // One priority-line bit per cycle after a first bit held two cycles from the request edge; lines toggle outside a request, direction also when carried on priority
  always @(negedge core_clk) begin
    load = two_bit ? {pri_val, dir} : {pri_val[0], dir, 1'h0};
    peer_request <= start;
    if (start && !peer_request) begin
      peer_priority <= load[2];
      // First bit stands a second cycle: the device takes it one cycle after the request
      seq <= load;
    end else begin
      peer_priority <= start ? seq[2] : ~peer_priority;
      seq <= {seq[1:0], ~seq[0]};
    end
    peer_direction <= (start && !dir_on_pri) ? dir : ~peer_direction;
    peer_band_overlap <= start ? overlap : ~peer_band_overlap;
  end
endmodule : cta_peer_model

/* File: dv/cta_arbiter_tb.sv */
// Self-checking bench for the coexistence arbiter port.
// Assumes the peer model drives the radio lines; the bench drives config and local state.
`timescale 1ns/10ps
module cta_arbiter_tb;
  logic       core_clk, resetn, start, dir, overlap;
  logic       peer_request, peer_priority, peer_direction, peer_band_overlap, peer_grant;
  logic       cfg_pri_used, cfg_pri_two, cfg_dir_used, cfg_band_used, local_busy, local_tx;
  logic [1:0] cfg_pri_threshold, req_priority, pri_val;
  logic       req_direction;
  int         n_fail, checked, seed;

  cta_peer_model peer (.core_clk(core_clk), .start(start), .pri_val(pri_val),
    .two_bit(cfg_pri_two), .dir_on_pri(cfg_pri_used & ~cfg_dir_used), .dir(dir),
    .overlap(overlap), .peer_request(peer_request), .peer_priority(peer_priority),
    .peer_direction(peer_direction), .peer_band_overlap(peer_band_overlap));

  cta_arbiter DUT (.core_clk(core_clk), .resetn(resetn), .peer_request(peer_request),
    .peer_priority(peer_priority), .peer_direction(peer_direction),
    .peer_band_overlap(peer_band_overlap), .peer_grant(peer_grant),
    .cfg_pri_used(cfg_pri_used), .cfg_pri_two(cfg_pri_two), .cfg_dir_used(cfg_dir_used),
    .cfg_band_used(cfg_band_used), .cfg_pri_threshold(cfg_pri_threshold),
    .local_busy(local_busy), .local_tx(local_tx), .req_priority(req_priority),
    .req_direction(req_direction));

  // Clock generator
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  // Expected priority, direction and grant
  function automatic logic [1:0] exp_pri();
    return !cfg_pri_used ? 2'h0 : (cfg_pri_two ? pri_val : {1'h0, pri_val[0]});
  endfunction : exp_pri
  function automatic logic exp_dir();
    return (cfg_dir_used || cfg_pri_used) ? dir : cta_pkg::DIR_DEFAULT;
  endfunction : exp_dir
  function automatic logic exp_gnt();
    // Without a priority line the peer outranks a busy local radio only for receive beside local receive
    return !(local_busy && (!cfg_band_used || overlap)
      && !(cfg_pri_used && exp_pri() >= cfg_pri_threshold)
      && !(exp_dir() == cta_pkg::DIR_RX && !local_tx && !cfg_pri_used));
  endfunction : exp_gnt

  // Compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // One request with its config, checked while held and after release
  task automatic trial(input logic [11:0] v);
    @(negedge core_clk);
    {cfg_pri_used, cfg_pri_two, cfg_dir_used, cfg_band_used, cfg_pri_threshold,
      local_busy, local_tx, pri_val, dir, overlap} <= v;
    start <= 1'h1;
    repeat (10) @(negedge core_clk);
    check({1'h0, peer_grant, req_priority}, {1'h0, exp_gnt(), exp_pri()});
    check({3'h0, req_direction}, {3'h0, exp_dir()});
    start <= 1'h0;
    repeat (6) @(negedge core_clk);
    check({3'h0, peer_grant}, 4'h0);
  endtask : trial

  // Reset, corner cases, then random requests
  initial begin
    n_fail = 0;
    checked = 0;
    resetn = 1'h0;
    start = 1'h0;
    {cfg_pri_used, cfg_pri_two, cfg_dir_used, cfg_band_used, cfg_pri_threshold} = 6'h00;
    {local_busy, local_tx, pri_val, dir, overlap} = 6'h00;
    seed = $urandom(25);
    repeat (16) @(negedge core_clk);
    resetn = 1'h1;
    repeat (4) @(negedge core_clk);
    check({peer_grant, req_direction, req_priority}, 4'h4);
    trial(12'h063);
    trial(12'h260);
    trial(12'hDBB);
    trial(12'hDB7);
    trial(12'h961);
    trial(12'h1F2);
    repeat (40) trial(12'($urandom()));
    stop_test();
  end

  // Watchdog
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule : cta_arbiter_tb
